//--- pkg/csq_params.svh
// Purpose: Constants for the charge sequencer and status signalling block.
// Assumes: 50 MHz core clock; register data sits in the low byte.
// Notes:   Times are kept in their own units; tick counts derive from them.
`ifndef CSQ_PARAMS_SVH
`define CSQ_PARAMS_SVH

// Clock and base tick.
`define CSQ_CLK_NS          20
`define CSQ_TICK_NS         125000
`define CSQ_TICK_CYCLES     (`CSQ_TICK_NS / `CSQ_CLK_NS)
`define CSQ_TICKS_PER_MS    (1000000 / `CSQ_TICK_NS)

// Interval lengths in their printed units.
`define CSQ_DEAD_BATTERY_TIMER_MIN      30
`define CSQ_SHORT_WATCHDOG_TIMER_S          32
`define CSQ_ABS_RAISE_MS    128
`define CSQ_ABS_WIN_MS      64
`define CSQ_LOAD_MS         132
`define CSQ_RCH_DEB_MS      132
`define CSQ_BATTERY_MISSING_FLAG_WAIT_S    2
`define CSQ_STAT_PULSE_US   125

// Interval lengths in ticks.
`define CSQ_DEAD_BATTERY_TIMER_TICKS    (`CSQ_DEAD_BATTERY_TIMER_MIN * 60000 * `CSQ_TICKS_PER_MS)
`define CSQ_SHORT_WATCHDOG_TIMER_TICKS      (`CSQ_SHORT_WATCHDOG_TIMER_S * 1000 * `CSQ_TICKS_PER_MS)
`define CSQ_ABS_RAISE_TICKS (`CSQ_ABS_RAISE_MS * `CSQ_TICKS_PER_MS)
`define CSQ_ABS_WIN_TICKS   (`CSQ_ABS_WIN_MS * `CSQ_TICKS_PER_MS)
`define CSQ_LOAD_TICKS      (`CSQ_LOAD_MS * `CSQ_TICKS_PER_MS)
`define CSQ_RCH_DEB_TICKS   (`CSQ_RCH_DEB_MS * `CSQ_TICKS_PER_MS)
`define CSQ_BATTERY_MISSING_FLAG_TICKS     (`CSQ_BATTERY_MISSING_FLAG_WAIT_S * 1000 * `CSQ_TICKS_PER_MS)
`define CSQ_PULSE_TICKS     ((`CSQ_STAT_PULSE_US * 1000) / `CSQ_TICK_NS)

// Register indices; the byte address is four times the index.
`define CSQ_IDX_INT         1
`define CSQ_IDX_CTRL        2
`define CSQ_IDX_IBAT        3
`define CSQ_IDX_MASK        6
`define CSQ_IDX_STAT        7
`define CSQ_IDX_WDOG        10
`define CSQ_IDX_OPT         11
`define CSQ_ADDR_INT        (`CSQ_IDX_INT * 4)
`define CSQ_ADDR_CTRL       (`CSQ_IDX_CTRL * 4)
`define CSQ_ADDR_IBAT       (`CSQ_IDX_IBAT * 4)
`define CSQ_ADDR_MASK       (`CSQ_IDX_MASK * 4)
`define CSQ_ADDR_STAT       (`CSQ_IDX_STAT * 4)
`define CSQ_ADDR_WDOG       (`CSQ_IDX_WDOG * 4)
`define CSQ_ADDR_OPT        (`CSQ_IDX_OPT * 4)

// Field positions.
`define CSQ_INT_SUMMARY_BIT 0
`define CSQ_CTRL_HZ_BIT     1
`define CSQ_CTRL_AUXOFF_BIT 4
`define CSQ_IBAT_ICHG_LSB   4
`define CSQ_IBAT_TERMINATION_CURRENT_FIELD_LSB  0
`define CSQ_WDOG_KICK_BIT   7
`define CSQ_OPT_TERMDIS_BIT 0
`define CSQ_OPT_RCHDIS_BIT  1
`define CSQ_OPT_PTM_BIT     2
`define CSQ_FLAG_BATTERY_MISSING_FLAG      0
`define CSQ_FLAG_WDOG       1
`define CSQ_FLAG_DBT        2
`define CSQ_FLAG_TERM       3
`define CSQ_STAT_STATE_LSB  4

// Reset values.
`define CSQ_CTRL_RST        8'h00
`define CSQ_IBAT_RST        8'h00
`define CSQ_MASK_RST        8'h00
`define CSQ_OPT_RST         8'h00

`endif

//--- pkg/csq_pkg.sv
// Purpose: Types of the charge sequencer and status signalling block.
// Assumes: Constants live in csq_params.svh.
// Notes:   All state of each module is one packed struct.
package csq_pkg;

  typedef enum logic [3:0] {
    CSQ_OFF        = 4'h0,
    CSQ_TRICKLE    = 4'h1,
    CSQ_ABS_TEST   = 4'h2,
    CSQ_CHARGE     = 4'h3,
    CSQ_TERM_LOAD  = 4'h4,
    CSQ_DONE       = 4'h5,
    CSQ_BATTERY_MISSING_FLAG      = 4'h6,
    CSQ_ABSENT     = 4'h7,
    CSQ_WD_IDLE    = 4'h8,
    CSQ_DB_EXPIRED = 4'h9
  } csq_chg_type;

  typedef enum logic [2:0] {
    CSQ_P_REST = 3'h0,
    CSQ_P_WAIT = 3'h1,
    CSQ_P_PRE  = 3'h2,
    CSQ_P_LOW  = 3'h3,
    CSQ_P_POST = 3'h4
  } csq_pin_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } csq_tick_state_type;

  typedef struct packed {
    csq_chg_type chg;
    csq_pin_type pin;
    logic [23:0] phase_cnt;
    logic [23:0] db_cnt;
    logic        db_run;
    logic [23:0] wd_cnt;
    logic        wd_en;
    logic [3:0]  pcnt;
    logic        vbus_ok_d;
    logic        pin_d;
    logic [7:0]  ctrl;
    logic [7:0]  ibat;
    logic [7:0]  opt;
    logic [7:0]  mask;
    logic [3:0]  flags;
    logic        summary;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        charge_en;
    logic        trickle;
    logic        target_raise;
    logic        load_on;
    logic        factory_test_mode;
    logic        regs_ctrl;
    logic        limit_500;
    logic        aux_bat;
    logic        aux_bus;
    logic        stat_pin;
  } csq_state_type;

endpackage : csq_pkg

//--- rtl/csq_tick.sv
// Purpose: Free-running base tick for every interval of the sequencer.
// Assumes: TICK_CYCLES is at least 2.
// Notes:   One pulse of one clock every TICK_CYCLES enabled cycles.
`timescale 1ns/1ns
module csq_tick #(
  parameter logic [15:0] TICK_CYCLES = 16'h186A
) (
  // Clock, reset and enable
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // Tick
  output logic      tick_out
);

  csq_pkg::csq_tick_state_type s_reg;
  csq_pkg::csq_tick_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt == TICK_CYCLES - 16'h0001) begin
      s_next.cnt  = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt  = s_reg.cnt + 16'h0001;
      s_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign tick_out = s_reg.tick;

endmodule : csq_tick

//--- rtl/csq_top.sv
// Purpose: Charge sequencing, watchdogs and status pin signalling.
// Assumes: Analog comparator levels arrive synchronous to clock_in.
// Notes:   Registers are reached over APB; all outputs are flip-flops.
//
// Functional notes
// - Dead pin high: regulator follows higher of battery, bus.
// - Pin low or disable bit: bus only, off below minimum.
// - Battery below short threshold: trickle current only.
// - Thirty-minute timer ends shorted charging; reconnect restarts.
// - Absence test raises target; high within window means absent.
// - Absence resets registers, sets flag, interrupts, pin high.
// - Absent: supply only with timer running, no disables.
// - Later absence test only after enabled termination.
// - Write after pin high swaps thirty-minute for watchdog.
// - Limit pin or register field sets charge current.
// - Host kicks watchdog; expiry stops charging into idle.
// - Idle left by reconnect, pin low or starting write.
// - Termination current stops charging and halts watchdog.
// - Termination load; low voltage means missing battery fault.
// - Fault restarts after two seconds, trickle or charge.
// - Missing flag cleared by passed test or power-on above short threshold.
// - Debounced recharge restarts fast charge unless disabled.
// - Factory test: flag and enable; voltage loop, watchdog stops.
// - Unmasked event gives one low status pulse if summary bit clear.
// - Status rests low only charging with battery present.
// - Low rest adds leading high; trailing high if charging.
// - Summary bit set before pulse, cleared by reading.
`timescale 1ns/1ns
`include "csq_params.svh"
module csq_top #(
  parameter logic [15:0] TICK_CYCLES = 16'(`CSQ_TICK_CYCLES)
) (
  // Clock, reset and enable
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Comparators and pins
  input  wire logic        vbus_ok_in,
  input  wire logic        vbus_gt_vbat_in,
  input  wire logic        vbat_above_short_in,
  input  wire logic        vbat_above_absent_in,
  input  wire logic        vbat_below_recharge_in,
  input  wire logic        ibat_below_term_in,
  input  wire logic        dead_battery_pin_in,
  input  wire logic        current_limit_pin_in,
  input  wire logic        charge_disable_input_in,
  // Charger controls
  output logic             charge_enable_out,
  output logic             trickle_out,
  output logic             target_raise_out,
  output logic             absence_load_out,
  output logic             voltage_loop_only_out,
  output logic             regs_control_current_out,
  output logic             bus_limit_500_out,
  output logic      [3:0]  charge_current_field_out,
  output logic      [3:0]  termination_current_field_out,
  output logic             aux_from_battery_out,
  output logic             aux_from_bus_out,
  output logic             status_pin_out
);

  csq_pkg::csq_state_type s_reg;
  csq_pkg::csq_state_type s_next;
  logic                   tick;

  ////////////////////////////////////////////////////////////////////////////
  // Base tick shared by every interval.
  csq_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .tick_out    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic        por;
    logic        pin_fall;
    logic        a_int;
    logic        a_ctrl;
    logic        a_ibat;
    logic        a_mask;
    logic        a_stat;
    logic        a_wdog;
    logic        a_opt;
    logic        mapped;
    logic        acc;
    logic        wr;
    logic        rd_int;
    logic        rd_stat;
    logic        factory_test_mode;
    logic        gate;
    logic        wd_run;
    logic        reg_reset;
    logic        rest;
    logic        trig;
    logic [3:0]  ev;
    logic [3:0]  clr;
    csq_pkg::csq_chg_type start_st;
    por       = vbus_ok_in && !s_reg.vbus_ok_d;
    pin_fall  = vbus_ok_in && s_reg.pin_d && !dead_battery_pin_in;
    a_int     = (paddr_in == 8'(`CSQ_ADDR_INT));
    a_ctrl    = (paddr_in == 8'(`CSQ_ADDR_CTRL));
    a_ibat    = (paddr_in == 8'(`CSQ_ADDR_IBAT));
    a_mask    = (paddr_in == 8'(`CSQ_ADDR_MASK));
    a_stat    = (paddr_in == 8'(`CSQ_ADDR_STAT));
    a_wdog    = (paddr_in == 8'(`CSQ_ADDR_WDOG));
    a_opt     = (paddr_in == 8'(`CSQ_ADDR_OPT));
    mapped    = a_int | a_ctrl | a_ibat | a_mask | a_stat | a_wdog | a_opt;
    acc       = psel_in && penable_in && s_reg.pready;
    wr        = acc && pwrite_in && mapped;
    rd_int    = acc && !pwrite_in && a_int;
    rd_stat   = acc && !pwrite_in && a_stat;
    factory_test_mode       = s_reg.opt[`CSQ_OPT_PTM_BIT] && s_reg.flags[`CSQ_FLAG_BATTERY_MISSING_FLAG];
    gate      = (s_reg.db_run || s_reg.wd_en) &&
                !s_reg.ctrl[`CSQ_CTRL_HZ_BIT] && !charge_disable_input_in;
    reg_reset = 1'b0;
    ev        = 4'h0;
    clr       = 4'h0;
    start_st  = vbat_above_short_in ? csq_pkg::CSQ_CHARGE
                                    : csq_pkg::CSQ_TRICKLE;
    s_next    = s_reg;
    s_next.vbus_ok_d = vbus_ok_in;
    s_next.pin_d     = dead_battery_pin_in;

    // APB: the answer comes in the first access cycle.
    s_next.pready  = psel_in && !penable_in;
    s_next.pslverr = psel_in && !penable_in && !mapped;
    if (psel_in && !penable_in) begin
      s_next.prdata  = 32'h0000_0000;
      if (a_int) begin
        s_next.prdata[`CSQ_INT_SUMMARY_BIT] = s_reg.summary;
      end
      if (a_ctrl) begin
        s_next.prdata[7:0] = s_reg.ctrl;
      end
      if (a_ibat) begin
        s_next.prdata[7:0] = s_reg.ibat;
      end
      if (a_mask) begin
        s_next.prdata[7:0] = s_reg.mask;
      end
      if (a_opt) begin
        s_next.prdata[7:0] = s_reg.opt;
      end
      if (a_stat) begin
        s_next.prdata[3:0] = s_reg.flags;
        s_next.prdata[`CSQ_STAT_STATE_LSB +: 4] = s_reg.chg;
      end
    end
    if (wr && a_ctrl) begin
      s_next.ctrl = pwdata_in[7:0];
    end
    if (wr && a_ibat) begin
      s_next.ibat = pwdata_in[7:0];
    end
    if (wr && a_mask) begin
      s_next.mask = pwdata_in[7:0];
    end
    if (wr && a_opt) begin
      s_next.opt = pwdata_in[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog and thirty-minute timer.
    wd_run = s_reg.wd_en && !factory_test_mode && s_reg.chg != csq_pkg::CSQ_TERM_LOAD &&
             s_reg.chg != csq_pkg::CSQ_DONE;
    if (wd_run && tick) begin
      s_next.wd_cnt = s_reg.wd_cnt + 24'h000001;
    end
    if (wr && a_wdog && pwdata_in[`CSQ_WDOG_KICK_BIT]) begin
      s_next.wd_cnt = 24'h000000;
    end
    if (s_reg.db_run && tick) begin
      s_next.db_cnt = s_reg.db_cnt + 24'h000001;
    end
    if (wr && dead_battery_pin_in && !s_reg.wd_en) begin
      s_next.db_run = 1'b0;
      s_next.db_cnt = 24'h000000;
      s_next.wd_en  = 1'b1;
      s_next.wd_cnt = 24'h000000;
      if (s_reg.chg == csq_pkg::CSQ_WD_IDLE) begin
        s_next.chg = start_st;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Charge sequence.
    case (s_reg.chg)
      csq_pkg::CSQ_TRICKLE: begin
        if (vbat_above_short_in) begin
          s_next.chg = csq_pkg::CSQ_ABS_TEST;
        end
      end
      csq_pkg::CSQ_ABS_TEST: begin
        if (vbat_above_absent_in &&
            s_reg.phase_cnt < 24'(`CSQ_ABS_WIN_TICKS)) begin
          ev[`CSQ_FLAG_BATTERY_MISSING_FLAG] = 1'b1;
          reg_reset  = 1'b1;
          s_next.chg = csq_pkg::CSQ_ABSENT;
        end else if (tick &&
            s_reg.phase_cnt == 24'(`CSQ_ABS_RAISE_TICKS - 1)) begin
          clr[`CSQ_FLAG_BATTERY_MISSING_FLAG] = 1'b1;
          s_next.chg = csq_pkg::CSQ_CHARGE;
        end
      end
      csq_pkg::CSQ_CHARGE: begin
        if (ibat_below_term_in && s_reg.charge_en &&
            !s_reg.opt[`CSQ_OPT_TERMDIS_BIT]) begin
          ev[`CSQ_FLAG_TERM] = 1'b1;
          s_next.chg = csq_pkg::CSQ_TERM_LOAD;
        end
      end
      csq_pkg::CSQ_TERM_LOAD: begin
        if (!vbat_below_recharge_in) begin
          s_next.chg = csq_pkg::CSQ_DONE;
        end else if (tick &&
            s_reg.phase_cnt == 24'(`CSQ_LOAD_TICKS - 1)) begin
          ev[`CSQ_FLAG_BATTERY_MISSING_FLAG] = 1'b1;
          s_next.chg = csq_pkg::CSQ_BATTERY_MISSING_FLAG;
        end
      end
      csq_pkg::CSQ_DONE: begin
        if (!vbat_below_recharge_in || s_reg.opt[`CSQ_OPT_RCHDIS_BIT]) begin
          s_next.phase_cnt = 24'h000000;
        end else if (tick &&
            s_reg.phase_cnt == 24'(`CSQ_RCH_DEB_TICKS - 1)) begin
          s_next.chg = csq_pkg::CSQ_CHARGE;
        end
      end
      csq_pkg::CSQ_BATTERY_MISSING_FLAG: begin
        if (tick && s_reg.phase_cnt == 24'(`CSQ_BATTERY_MISSING_FLAG_TICKS - 1)) begin
          s_next.chg = start_st;
        end
      end
      csq_pkg::CSQ_OFF,
      csq_pkg::CSQ_ABSENT,
      csq_pkg::CSQ_WD_IDLE,
      csq_pkg::CSQ_DB_EXPIRED: begin
        s_next.chg = s_next.chg;
      end
      default: begin
        s_next.chg = csq_pkg::CSQ_OFF;
      end
    endcase
    if (tick && s_next.chg == s_reg.chg &&
        (s_reg.chg == csq_pkg::CSQ_ABS_TEST ||
         s_reg.chg == csq_pkg::CSQ_TERM_LOAD ||
         s_reg.chg == csq_pkg::CSQ_BATTERY_MISSING_FLAG ||
         (s_reg.chg == csq_pkg::CSQ_DONE && vbat_below_recharge_in &&
          !s_reg.opt[`CSQ_OPT_RCHDIS_BIT]))) begin
      s_next.phase_cnt = s_reg.phase_cnt + 24'h000001;
    end

    // Later assignments win: supply loss overrides everything.
    if (wd_run && tick && s_reg.wd_cnt == 24'(`CSQ_SHORT_WATCHDOG_TIMER_TICKS - 1)) begin
      ev[`CSQ_FLAG_WDOG] = 1'b1;
      s_next.wd_en  = 1'b0;
      s_next.chg    = csq_pkg::CSQ_WD_IDLE;
    end
    if (s_reg.db_run && tick &&
        s_reg.db_cnt == 24'(`CSQ_DEAD_BATTERY_TIMER_TICKS - 1)) begin
      ev[`CSQ_FLAG_DBT] = 1'b1;
      s_next.db_run = 1'b0;
      s_next.chg    = csq_pkg::CSQ_DB_EXPIRED;
    end
    if (pin_fall || por) begin
      reg_reset     = reg_reset || !dead_battery_pin_in;
      s_next.db_run = 1'b1;
      s_next.db_cnt = 24'h000000;
      s_next.wd_en  = 1'b0;
      s_next.wd_cnt = 24'h000000;
      s_next.chg    = start_st;
      if (por && vbat_above_short_in) begin
        clr[`CSQ_FLAG_BATTERY_MISSING_FLAG] = 1'b1;
      end
    end
    if (!vbus_ok_in) begin
      s_next.db_run = 1'b0;
      s_next.wd_en  = 1'b0;
      s_next.chg    = csq_pkg::CSQ_OFF;
    end
    if (s_next.chg != s_reg.chg) begin
      s_next.phase_cnt = 24'h000000;
    end
    if (reg_reset) begin
      s_next.ctrl = `CSQ_CTRL_RST;
      s_next.ibat = `CSQ_IBAT_RST;
      s_next.opt  = `CSQ_OPT_RST;
      s_next.mask = `CSQ_MASK_RST;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, summary bit and status pin; a new event beats a clear.
    if (rd_stat) begin
      clr = clr | 4'hE;
    end
    s_next.flags   = (s_reg.flags & ~clr) | ev;
    trig           = |(ev & ~s_reg.mask[3:0]) && !s_reg.summary;
    s_next.summary = (s_reg.summary && !rd_int) || |(ev & ~s_reg.mask[3:0]);
    rest = !(s_reg.charge_en && !s_reg.flags[`CSQ_FLAG_BATTERY_MISSING_FLAG]);
    case (s_reg.pin)
      csq_pkg::CSQ_P_REST: begin
        if (trig) begin
          s_next.pin = csq_pkg::CSQ_P_WAIT;
        end
      end
      csq_pkg::CSQ_P_WAIT: begin
        if (tick) begin
          s_next.pcnt = 4'h0;
          s_next.pin  = rest ? csq_pkg::CSQ_P_LOW : csq_pkg::CSQ_P_PRE;
        end
      end
      csq_pkg::CSQ_P_PRE,
      csq_pkg::CSQ_P_LOW,
      csq_pkg::CSQ_P_POST: begin
        if (tick) begin
          s_next.pcnt = s_reg.pcnt + 4'h1;
          if (s_reg.pcnt == 4'(`CSQ_PULSE_TICKS - 1)) begin
            s_next.pcnt = 4'h0;
            if (s_reg.pin == csq_pkg::CSQ_P_PRE) begin
              s_next.pin = csq_pkg::CSQ_P_LOW;
            end else if (s_reg.pin == csq_pkg::CSQ_P_LOW && !rest) begin
              s_next.pin = csq_pkg::CSQ_P_POST;
            end else begin
              s_next.pin = csq_pkg::CSQ_P_REST;
            end
          end
        end
      end
      default: begin
        s_next.pin = csq_pkg::CSQ_P_REST;
      end
    endcase
    case (s_next.pin)
      csq_pkg::CSQ_P_LOW:  s_next.stat_pin = 1'b0;
      csq_pkg::CSQ_P_PRE,
      csq_pkg::CSQ_P_POST: s_next.stat_pin = 1'b1;
      default:             s_next.stat_pin = rest;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Charger and regulator controls.
    s_next.charge_en = gate && (s_next.chg == csq_pkg::CSQ_TRICKLE ||
                                s_next.chg == csq_pkg::CSQ_ABS_TEST ||
                                s_next.chg == csq_pkg::CSQ_CHARGE ||
                                s_next.chg == csq_pkg::CSQ_ABSENT);
    s_next.trickle      = s_next.chg == csq_pkg::CSQ_TRICKLE;
    s_next.target_raise = s_next.chg == csq_pkg::CSQ_ABS_TEST;
    s_next.load_on      = s_next.chg == csq_pkg::CSQ_TERM_LOAD;
    s_next.factory_test_mode          = factory_test_mode;
    s_next.regs_ctrl    = s_next.wd_en;
    s_next.limit_500    = current_limit_pin_in;
    if (dead_battery_pin_in && !s_next.ctrl[`CSQ_CTRL_AUXOFF_BIT]) begin
      s_next.aux_bat = !vbus_gt_vbat_in;
      s_next.aux_bus = vbus_gt_vbat_in;
    end else begin
      s_next.aux_bat = 1'b0;
      s_next.aux_bus = vbus_ok_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign prdata_out                    = s_reg.prdata;
  assign pready_out                    = s_reg.pready;
  assign pslverr_out                   = s_reg.pslverr;
  assign charge_enable_out             = s_reg.charge_en;
  assign trickle_out                   = s_reg.trickle;
  assign target_raise_out              = s_reg.target_raise;
  assign absence_load_out              = s_reg.load_on;
  assign voltage_loop_only_out         = s_reg.factory_test_mode;
  assign regs_control_current_out      = s_reg.regs_ctrl;
  assign bus_limit_500_out             = s_reg.limit_500;
  assign charge_current_field_out      = s_reg.ibat[`CSQ_IBAT_ICHG_LSB +: 4];
  assign termination_current_field_out = s_reg.ibat[`CSQ_IBAT_TERMINATION_CURRENT_FIELD_LSB +: 4];
  assign aux_from_battery_out          = s_reg.aux_bat;
  assign aux_from_bus_out              = s_reg.aux_bus;
  assign status_pin_out                = s_reg.stat_pin;

endmodule : csq_top

//--- sim/charge_sequencer_status_signaling_tb.sv
// Purpose: Register and sequencing checks of csq_top.
// Assumes: Short tick so an absence test fits in a short run.
// Notes:   Watchdog and thirty-minute expiry are too long to run.
`timescale 1ns/1ns
`include "csq_params.svh"
module charge_sequencer_status_signaling_tb;
  logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic vbus_ok_in = 0, vbus_gt_vbat_in = 0, vbat_above_short_in = 0;
  logic vbat_above_absent_in = 0, vbat_below_recharge_in = 0;
  logic ibat_below_term_in = 0, dead_battery_pin_in = 1;
  logic current_limit_pin_in = 0, charge_disable_input_in = 0;
  logic charge_enable_out, trickle_out, target_raise_out;
  logic absence_load_out, voltage_loop_only_out, bus_limit_500_out;
  logic regs_control_current_out, aux_from_battery_out;
  logic aux_from_bus_out, status_pin_out;
  logic [3:0] charge_current_field_out, termination_current_field_out;
  int failures = 0, samples_checked = 0, p0;
  csq_top #(.TICK_CYCLES(16'h0004)) DUT (.*);
  csq_host host (.clock_in, .rst_in, .psel_out(psel_in),
    .penable_out(penable_in), .pwrite_out(pwrite_in), .paddr_out(paddr_in),
    .pwdata_out(pwdata_in), .prdata_in(prdata_out), .pready_in(pready_out),
    .pslverr_in(pslverr_out), .status_pin_in(status_pin_out));
  always #10 clock_in = ~clock_in;
  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task close_out(input logic hung);
    if (hung) failures++;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wt
  task rd(input logic [7:0] a, input logic [31:0] want, input logic err,
          input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    check(q & m, want);
    check(e, err);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
  endtask : wr
  ////////////////////////////////////////
  initial begin
    wt(3);
    rst_in <= 1'b0;
    wt(3);
    check(aux_from_battery_out, 1);
    rd(`CSQ_ADDR_STAT, 0, 0);
    rd(8'h30, 0, 1);
    vbus_ok_in <= 1'b1;
    vbus_gt_vbat_in <= 1'b1;
    wt(4);
    check({aux_from_bus_out, aux_from_battery_out}, 2);
    check(trickle_out, 1);
    wr(`CSQ_ADDR_IBAT, 32'hA5);
    rd(`CSQ_ADDR_IBAT, 32'hA5, 0);
    check({charge_current_field_out, termination_current_field_out}, 8'hA5);
    check(regs_control_current_out, 1);
    current_limit_pin_in <= 1'b1;
    wt(2);
    check(bus_limit_500_out, 1);
    p0 = host.pulses;
    vbat_above_short_in <= 1'b1;
    wt(4);
    check({target_raise_out, trickle_out}, 2);
    vbat_above_absent_in <= 1'b1;
    wt(10);
    check({target_raise_out, charge_current_field_out}, 0);
    rd(`CSQ_ADDR_STAT, 1, 0, 32'h1);
    wt(40);
    check(host.pulses - p0, 1);
    check(status_pin_out, 1);
    rd(`CSQ_ADDR_INT, 1, 0);
    rd(`CSQ_ADDR_INT, 0, 0);
    check(charge_enable_out, 1);
    wr(`CSQ_ADDR_OPT, 32'h4);
    wt(2);
    check(voltage_loop_only_out, 1);
    dead_battery_pin_in <= 1'b0;
    vbus_gt_vbat_in <= 1'b0;
    wt(4);
    check({aux_from_bus_out, aux_from_battery_out}, 2);
    ibat_below_term_in <= 1'b1;
    vbat_below_recharge_in <= 1'b1;
    wt(4);
    check({absence_load_out, charge_enable_out}, 2);
    vbus_ok_in <= 1'b0;
    wt(4);
    check(aux_from_bus_out, 0);
    close_out(1'b0);
  end
endmodule : charge_sequencer_status_signaling_tb

//--- sim/csq_checker.sv
// Purpose: Port-level properties of the charge sequencer.
// Assumes: One clock domain; ce_in is held high by the bench.
// Notes:   Bound to csq_top after the module.
`timescale 1ns/1ns
module csq_checker (
  // Clock and bus
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Pins and controls
  input wire logic        vbus_ok_in,
  input wire logic        dead_battery_pin_in,
  input wire logic        current_limit_pin_in,
  input wire logic        bus_limit_500_out,
  input wire logic        trickle_out,
  input wire logic        target_raise_out,
  input wire logic        aux_from_battery_out,
  input wire logic        aux_from_bus_out,
  input wire logic        status_pin_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_ready_after_setup: assert property
    (psel_in && !penable_in && ce_in |=> pready_out)
    else $error("ready missing after setup");
  a_refused_zero_data: assert property
    (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("refused access returned data");
  a_aux_one_source: assert property
    (!(aux_from_battery_out && aux_from_bus_out))
    else $error("regulator fed from two sources");
  a_aux_bus_low: assert property
    ((!vbus_ok_in) [*3] |-> !aux_from_bus_out)
    else $error("regulator on bus below threshold");
  a_aux_pin_low: assert property
    ((!dead_battery_pin_in) [*3] |-> !aux_from_battery_out)
    else $error("regulator on battery with pin low");
  a_limit_pin_copy: assert property
    (bus_limit_500_out == $past(current_limit_pin_in))
    else $error("limit output not following pin");
  a_trickle_not_test: assert property
    (trickle_out |-> !target_raise_out)
    else $error("trickle during absence test");
  c_refused: cover property (pslverr_out);
  c_trickle: cover property (trickle_out);
  c_pulse: cover property ($fell(status_pin_out));
endmodule : csq_checker
////////////////////////////////////////
bind csq_top csq_checker u_chk (.*);

//--- sim/csq_host.sv
// Purpose: Host model: APB master and status pin watcher.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   A stalled transfer ends the run through the bench.
`timescale 1ns/1ns
module csq_host (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // APB master
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [7:0]  paddr_out,
  output logic      [31:0] pwdata_out,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  // Status pin
  input  wire logic        status_pin_in
);
  int   pulses = 0;
  logic prev;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // Counts falling edges; every low pulse starts with one.
  always @(posedge clock_in) begin
    if (prev && !status_pin_in && !rst_in) pulses++;
    prev <= status_pin_in;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clock_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_in !== 1'b1 && n < 20);
    if (pready_in !== 1'b1)
      charge_sequencer_status_signaling_tb.close_out(1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    @(posedge clock_in);
  endtask : xfer
endmodule : csq_host
